// ===== design/eif_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 125 MHz system clock, 8-bit register port
// Notes:   definitions only
`ifndef EIF_MAP_SVH
`define EIF_MAP_SVH
// ==========================================================
// register offsets
`define EIF_CTL_OFS      8'h37
`define EIF_STAT_OFS     8'h40
`define EIF_MASK_OFS     8'h41
`define EIF_MODE_OFS     8'h42
// ==========================================================
// control fields
`define EIF_NC_BIT       7
`define EIF_PSEL_BIT     6
`define EIF_TRIG_HI      5
`define EIF_TRIG_LO      4
`define EIF_ES3_BIT      3
`define EIF_ES2_BIT      2
`define EIF_ES1_BIT      1
`define EIF_CTL_RST      8'h00
`define EIF_CTL_WMASK    8'hfe
// mode fields
`define EIF_MEN_BIT      0
`define EIF_SLOW_BIT     1
`define EIF_MODE_RST     2'h0
`define EIF_STAT_RST     6'h00
`define EIF_MASK_RST     6'h00
// ==========================================================
// clock rates
`define EIF_CLK_NS       8
`define EIF_HF_NS        16
`define EIF_LF_NS        30518
`define EIF_HF_DIV       (`EIF_HF_NS / `EIF_CLK_NS)
`define EIF_LF_DIV       (`EIF_LF_NS / `EIF_CLK_NS)
// accept counts in ticks of the selected clock
`define EIF_THR_FAST     8'h04
`define EIF_THR_MID      8'h10
`define EIF_THR_NC1      8'h20
`define EIF_THR_NC0      8'h60
`define EIF_THR_LF       8'h02
`endif

// ===== design/eif_pkg.sv
// Purpose: shared types of the external interrupt filter
// Assumes: constants live in eif_map.svh
// Notes:   types only
package eif_pkg;
   // ==========================================================
   // register port request
   typedef struct packed {
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
      logic       we;    // write strobe
      logic       re;    // read strobe
   } eif_bus_t;
   // trigger of input four
   typedef enum logic [1:0] {
      EIF_TRIG_RISE  = 2'b00,
      EIF_TRIG_FALL  = 2'b01,
      EIF_TRIG_BOTH  = 2'b10,
      EIF_TRIG_LEVEL = 2'b11
   } eif_trig_t;
   // filtered pin view
   typedef struct packed {
      logic ok;    // filter holds a valid level
      logic level; // filtered level
      logic rise;  // one-cycle rising pulse
      logic fall;  // one-cycle falling pulse
   } eif_flt_t;
endpackage

// ===== design/eif_filter.sv
// Purpose: one pin: two-stage synchroniser and pulse-width filter
// Assumes: tick is a one-cycle enable of the timing clock
// Notes:   threshold may change at any time, used at once
`timescale 1ns/10ps
module eif_filter
   import eif_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pin,
   input  wire logic       tick,
   input  wire logic [7:0] thr,
   output eif_flt_t        flt
);
   // ==========================================================
   // synchroniser
   logic       sync1_r;  // first stage, read by sync2_r only
   logic       sync2_r;  // settled pin level
   logic       lvl_r;    // filtered level
   logic       ok_r;     // level captured after reset
   logic       rise_r;   // rising pulse
   logic       fall_r;   // falling pulse
   logic [7:0] cnt_r;    // ticks of disagreement

   // two flops keep metastability off the counter
   always_ff @(posedge clk) begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
   end

   // ==========================================================
   // width filter
   wire       differ  = sync2_r != lvl_r;
   wire [7:0] cnt_inc = cnt_r + 8'h01;
   wire       accept  = ok_r && differ && tick && (cnt_inc >= thr);

   // any return to the held level restarts the count, so a
   // short glitch never accumulates across several pulses
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 8'h00;
      end else if (!differ || accept) begin
         cnt_r <= 8'h00;
      end else if (tick) begin
         cnt_r <= cnt_inc;
      end
   end

   // first cycle after reset takes the pin as is: no edge
   always_ff @(posedge clk) begin
      if (rst) begin
         ok_r  <= 1'b0;
         lvl_r <= 1'b0;
      end else if (!ok_r) begin
         ok_r  <= 1'b1;
         lvl_r <= sync2_r;
      end else if (accept) begin
         lvl_r <= sync2_r;
      end
   end

   // edge pulses
   always_ff @(posedge clk) begin
      if (rst) begin
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         rise_r <= accept && sync2_r;
         fall_r <= accept && !sync2_r;
      end
   end

   assign flt = '{ok: ok_r, level: lvl_r, rise: rise_r, fall: fall_r};

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_flt_needs_count;
      $changed(lvl_r) && $past(ok_r) |-> $past(accept);
   endproperty
   a_flt_needs_count: assert property (p_flt_needs_count)
      else $error("filtered level moved without full count");
endmodule // eif_filter

// ===== design/eif_top.sv
// Purpose: six external interrupt inputs with noise filters
// Assumes: register port is synchronous to clk
// Notes:   status W1C, mask gates one level interrupt
// Function
// - six inputs, each through its own filter
// - pin zero is port after reset
// - pin select low blocks input zero
// - zero and five falling, 2/7 fast-clock window
// - input one window picked by noise bit
// - two to four: 7/25 fast-clock window
// - slow mode: 1/3.5 slow-clock window
// - one to three: edge select bit
// - input four: rise, fall, both, high
// - four level needs rise after reset
// - latch set soon after filtered edge
// - noise bit change acts at once
// - control register at 37h, resets zero
// - zero needs master, flag, pin select
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "eif_map.svh"
module eif_top
   import eif_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  eif_bus_t        bus,
   output logic [7:0]      rdata,
   input  wire logic       ext_irq_zero,
   input  wire logic       ext_irq_one,
   input  wire logic       ext_irq_two,
   input  wire logic       ext_irq_three,
   input  wire logic       ext_irq_four,
   input  wire logic       ext_irq_five,
   output logic            irq
);
   // ==========================================================
   // registers
   logic [7:0]  ctl_r;     // ext_int_control
   logic [5:0]  stat_r;    // sticky latches
   logic [5:0]  mask_r;    // individual enable flags
   logic [1:0]  mode_r;    // master enable, slow mode
   logic [7:0]  rdata_r;   // read data, one cycle late
   logic        irq_r;     // interrupt output
   logic        armed_r;   // input four saw a rise
   logic [11:0] lf_cnt_r;  // low clock divider
   logic [3:0]  hf_cnt_r;  // high clock divider
   logic        lf_tick_r; // low clock enable
   logic        hf_tick_r; // high clock enable

   // ==========================================================
   // field views
   wire       nc_bit   = ctl_r[`EIF_NC_BIT];
   wire       pin_sel  = ctl_r[`EIF_PSEL_BIT];
   wire [1:0] trig_raw = ctl_r[`EIF_TRIG_HI:`EIF_TRIG_LO];
   eif_trig_t trig;
   assign trig = eif_trig_t'(trig_raw);
   wire       slow     = mode_r[`EIF_SLOW_BIT];
   wire       men      = mode_r[`EIF_MEN_BIT];

   // ==========================================================
   // clock dividers
   // both timing clocks are enables from clk, so no crossing
   always_ff @(posedge clk) begin
      if (rst) begin
         hf_cnt_r  <= 4'h0;
         hf_tick_r <= 1'b0;
      end else if (hf_cnt_r == 4'(`EIF_HF_DIV - 1)) begin
         hf_cnt_r  <= 4'h0;
         hf_tick_r <= 1'b1;
      end else begin
         hf_cnt_r  <= hf_cnt_r + 4'h1;
         hf_tick_r <= 1'b0;
      end
   end

   // low clock runs even in fast modes; only slow uses it
   always_ff @(posedge clk) begin
      if (rst) begin
         lf_cnt_r  <= 12'h000;
         lf_tick_r <= 1'b0;
      end else if (lf_cnt_r == 12'(`EIF_LF_DIV - 1)) begin
         lf_cnt_r  <= 12'h000;
         lf_tick_r <= 1'b1;
      end else begin
         lf_cnt_r  <= lf_cnt_r + 12'h001;
         lf_tick_r <= 1'b0;
      end
   end

   // in slow mode every pin counts low clock ticks
   wire tick = slow ? lf_tick_r : hf_tick_r;

   // ==========================================================
   // per-pin thresholds
   wire [7:0] thr_one = nc_bit ? `EIF_THR_NC1 : `EIF_THR_NC0;
   wire [7:0] thr_hf [6];
   assign thr_hf[0] = `EIF_THR_FAST;
   assign thr_hf[1] = thr_one;
   assign thr_hf[2] = `EIF_THR_MID;
   assign thr_hf[3] = `EIF_THR_MID;
   assign thr_hf[4] = `EIF_THR_MID;
   assign thr_hf[5] = `EIF_THR_FAST;

   wire [5:0] pins = {ext_irq_five, ext_irq_four, ext_irq_three,
                      ext_irq_two, ext_irq_one, ext_irq_zero};
   eif_flt_t  flt [6];

   // ==========================================================
   // filters, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_pin
         wire [7:0] thr = slow ? `EIF_THR_LF : thr_hf[gi];
         eif_filter u_flt (
            .clk  (clk),
            .rst  (rst),
            .pin  (pins[gi]),
            .tick (tick),
            .thr  (thr),
            .flt  (flt[gi])
         );
      end
   endgenerate

   // ==========================================================
   // trigger decode
   wire es1 = ctl_r[`EIF_ES1_BIT];
   wire es2 = ctl_r[`EIF_ES2_BIT];
   wire es3 = ctl_r[`EIF_ES3_BIT];
   wire ev0 = flt[0].fall && pin_sel;
   wire ev1 = es1 ? flt[1].fall : flt[1].rise;
   wire ev2 = es2 ? flt[2].fall : flt[2].rise;
   wire ev3 = es3 ? flt[3].fall : flt[3].rise;
   wire ev5 = flt[5].fall;
   logic ev4; // input four condition
   // level mode waits for a rise seen after reset
   always_comb begin
      unique case (trig)
         EIF_TRIG_RISE:  ev4 = flt[4].rise;
         EIF_TRIG_FALL:  ev4 = flt[4].fall;
         EIF_TRIG_BOTH:  ev4 = flt[4].rise || flt[4].fall;
         EIF_TRIG_LEVEL: ev4 = flt[4].level && armed_r;
      endcase
   end
   wire [5:0] set_vec = {ev5, ev4, ev3, ev2, ev1, ev0};

   // a pin already high at reset gives no rise, so no arming
   always_ff @(posedge clk) begin
      if (rst) begin
         armed_r <= 1'b0;
      end else if (flt[4].rise) begin
         armed_r <= 1'b1;
      end
   end

   // ==========================================================
   // register decode
   wire hit_ctl  = bus.addr == `EIF_CTL_OFS;
   wire hit_stat = bus.addr == `EIF_STAT_OFS;
   wire hit_mask = bus.addr == `EIF_MASK_OFS;
   wire hit_mode = bus.addr == `EIF_MODE_OFS;
   wire wr_ctl   = bus.we && hit_ctl;
   wire wr_stat  = bus.we && hit_stat;
   wire wr_mask  = bus.we && hit_mask;
   wire wr_mode  = bus.we && hit_mode;

   // control: bit 0 is unused and holds zero
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_r <= `EIF_CTL_RST;
      end else if (wr_ctl) begin
         ctl_r <= bus.wdata & `EIF_CTL_WMASK;
      end
   end

   // status: write one clears, a new event wins the clear
   wire [5:0] clr_vec  = wr_stat ? bus.wdata[5:0] : 6'h00;
   wire [5:0] stat_nxt = (stat_r & ~clr_vec) | set_vec;
   always_ff @(posedge clk) begin
      if (rst) begin
         stat_r <= `EIF_STAT_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // mask and mode
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r <= `EIF_MASK_RST;
         mode_r <= `EIF_MODE_RST;
      end else begin
         if (wr_mask) begin
            mask_r <= bus.wdata[5:0];
         end
         if (wr_mode) begin
            mode_r <= bus.wdata[1:0];
         end
      end
   end

   // ==========================================================
   // interrupt output
   // zero is gated again by pin select so a port pin never asks
   wire [5:0] gate     = {mask_r[5:1], mask_r[0] && pin_sel};
   wire       irq_nxt  = men && |(stat_nxt & gate);
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end
   assign irq = irq_r;

   // ==========================================================
   // read path
   logic [7:0] rd_mux; // selected register
   always_comb begin
      rd_mux = 8'h00; // unmapped reads zero
      if (hit_ctl) begin
         rd_mux = ctl_r;
      end else if (hit_stat) begin
         rd_mux = {2'h0, stat_r};
      end else if (hit_mask) begin
         rd_mux = {2'h0, mask_r};
      end else if (hit_mode) begin
         rd_mux = {6'h00, mode_r};
      end
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (bus.re) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign rdata = rdata_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_ctl_reset;
      $past(rst) |-> ctl_r == 8'h00 && !pin_sel;
   endproperty
   a_ctl_reset: assert property (p_ctl_reset)
      else $error("control not zero after reset");

   property p_zero_blocked;
      !pin_sel && flt[0].fall |=> !$rose(stat_r[0]);
   endproperty
   a_zero_blocked: assert property (p_zero_blocked)
      else $error("input zero latched while port");

   property p_five_fall;
      $rose(stat_r[5]) |-> $past(flt[5].fall);
   endproperty
   a_five_fall: assert property (p_five_fall)
      else $error("input five latched without fall");

   property p_one_edge;
      $rose(stat_r[1]) |->
         $past(es1 ? flt[1].fall : flt[1].rise);
   endproperty
   a_one_edge: assert property (p_one_edge)
      else $error("input one latched on wrong edge");

   property p_four_level;
      trig == EIF_TRIG_LEVEL && !armed_r |=> !$rose(stat_r[4]);
   endproperty
   a_four_level: assert property (p_four_level)
      else $error("level request before rise");

   property p_four_both;
      trig == EIF_TRIG_BOTH && flt[4].fall |=> stat_r[4];
   endproperty
   a_four_both: assert property (p_four_both)
      else $error("both-edge fall missed");

   property p_latch_time;
      ev2 |=> stat_r[2] ##1 stat_r[2] || $past(wr_stat);
   endproperty
   a_latch_time: assert property (p_latch_time)
      else $error("latch not set after edge");

   property p_zero_irq;
      irq && !$past(pin_sel) && $past(stat_nxt[5:1] & gate[5:1]) == 5'h00
         |-> 1'b0;
   endproperty
   a_zero_irq: assert property (p_zero_irq)
      else $error("interrupt from port pin zero");

   property p_irq_master;
      !$past(men) |-> !irq;
   endproperty
   a_irq_master: assert property (p_irq_master)
      else $error("interrupt with master off");

   property p_slow_thr;
      slow |-> g_pin[1].thr == `EIF_THR_LF;
   endproperty
   a_slow_thr: assert property (p_slow_thr)
      else $error("slow mode window wrong");

   property p_nc_now;
      $changed(nc_bit) && !slow |->
         g_pin[1].u_flt.thr == (nc_bit ? `EIF_THR_NC1 : `EIF_THR_NC0);
   endproperty
   a_nc_now: assert property (p_nc_now)
      else $error("noise select not applied");

   // read data must fall back to zero outside the answer cycle
   property p_rd_idle;
      !$past(bus.re) |-> rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside the answer cycle");

   property p_irq_cause;
      irq |-> |(stat_r & $past(mask_r));
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt with no unmasked status");

   // an event in the cycle of a clear must survive the clear
   property p_set_wins;
      wr_stat && |set_vec |=>
         (stat_r & $past(set_vec)) == $past(set_vec);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost under status clear");

   property p_four_armed;
      trig == EIF_TRIG_LEVEL && armed_r && flt[4].level |=> stat_r[4];
   endproperty
   a_four_armed: assert property (p_four_armed)
      else $error("high level request not latched");

   c_zero_set: cover property (pin_sel ##[1:8] $rose(stat_r[0]));
   c_four_lvl: cover property (armed_r && trig == EIF_TRIG_LEVEL
                               && ev4);
   c_irq_up:   cover property ($rose(irq));
   c_set_clr:  cover property (wr_stat && |(set_vec & bus.wdata[5:0]));
endmodule // eif_top

// ===== tb/eif_pin_src.sv
// Purpose: external sources on the six interrupt pins
// Assumes: pins change just after a rising clock edge
// Notes:   behavioural, commanded by the bench
`timescale 1ns/10ps
module eif_pin_src (
   input  wire logic  clk,
   output logic [5:0] pins
);
   // ==========================================================
   // idle high; input four sits high through reset
   initial pins = 6'h3f;
   // hold a new level on one pin
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge clk);
      pins[idx] <= lvl;
   endtask
   // invert one pin for len cycles, then restore it
   task automatic pulse(input int idx, input int len);
      logic old; // level to come back to
      old = pins[idx];
      @(posedge clk);
      pins[idx] <= ~old;
      repeat (len) @(posedge clk);
      pins[idx] <= old;
   endtask
endmodule // eif_pin_src

// ===== tb/eif_top_bench.sv
// Purpose: self-checking bench of the interrupt filter
// Assumes: pins come from eif_pin_src
// Notes:   widths drawn inside the reject and accept windows
`timescale 1ns/10ps
`include "eif_map.svh"
module eif_top_bench
   import eif_pkg::*;
;
   // ==========================================================
   // signals
   logic       clk;           // system clock
   logic       rst;           // synchronous reset
   eif_bus_t   bus;           // register port request
   logic [7:0] rdata;         // read data
   logic [5:0] pins;          // pin levels
   logic       irq;           // level interrupt
   int         bad_count = 0; // mismatches
   int         checks = 0;    // comparisons
   int         cyc = 0;       // cycles run
   int         i;             // input under test
   int         s;             // select value
   bit         nc;            // noise select of input one
   localparam int LIMIT = 80000; // about 1.7 times the run
   initial clk = 1'b0;
   // 8 ns clock
   always #4 clk = ~clk;
   // ==========================================================
   // design and sources
   eif_top i_eif_top (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .ext_irq_zero(pins[0]), .ext_irq_one(pins[1]),
      .ext_irq_two(pins[2]), .ext_irq_three(pins[3]),
      .ext_irq_four(pins[4]), .ext_irq_five(pins[5]), .irq(irq));
   eif_pin_src i_eif_pin_src (.clk(clk), .pins(pins));
   // ==========================================================
   // helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // one write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.we <= 1'b0;
   endtask
   // one read cycle, data compared in the cycle after
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.re <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // irq level a few cycles after a cause
   task automatic irq_is(input logic exp);
      repeat (3) @(posedge clk);
      #1 chk({7'h00, irq}, {7'h00, exp});
   endtask
   // reject bound in fast clock periods
   function automatic int rej(input int n, input bit b);
      if (n == 0 || n == 5) return 2;
      if (n == 1) return b ? 15 : 63;
      return 7;
   endfunction
   // accept bound in fast clock periods
   function automatic int acc(input int n, input bit b);
      if (n == 0 || n == 5) return 7;
      if (n == 1) return b ? 49 : 193;
      return 25;
   endfunction
   // one pulse shorter than reject or just past accept
   task automatic width(input int n, input bit b, input bit ok,
                        input bit sl);
      int lim; // bound in clk cycles
      int len; // pulse length
      if (sl)
         lim = ok ? (7 * `EIF_LF_DIV + 1) / 2 : `EIF_LF_DIV;
      else
         lim = (ok ? acc(n, b) : rej(n, b)) * `EIF_HF_DIV;
      len = ok ? lim + $urandom_range(20) : 1 + $urandom_range(lim - 2);
      i_eif_pin_src.pulse(n, len);
      repeat (sl ? 9000 : 250) @(posedge clk);
      rd(`EIF_STAT_OFS, ok ? 8'h01 << n : 8'h00);
      wr(`EIF_STAT_OFS, 8'h3f);
   endtask
   // verdict and end of run
   task automatic results;
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count++;
         results();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'hb17c762e));
      rst = 1'b1;
      bus = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(`EIF_CTL_OFS, `EIF_CTL_RST);
      rd(`EIF_STAT_OFS, 8'h00);
      rd(`EIF_MASK_OFS, 8'h00);
      rd(`EIF_MODE_OFS, 8'h00);
      @(posedge clk);
      #1 chk(rdata, 8'h00);
      wr(8'h38, 8'h5a);
      rd(8'h38, 8'h00);
      // level mode with input four already high
      wr(`EIF_CTL_OFS, 8'hff);
      rd(`EIF_CTL_OFS, `EIF_CTL_WMASK);
      wr(`EIF_MASK_OFS, 8'h10);
      wr(`EIF_MODE_OFS, 8'h01);
      repeat (60) @(posedge clk);
      rd(`EIF_STAT_OFS, 8'h00);
      i_eif_pin_src.pulse(4, 60);
      repeat (60) @(posedge clk);
      rd(`EIF_STAT_OFS, 8'h10);
      irq_is(1'b1);
      wr(`EIF_STAT_OFS, 8'h10);
      rd(`EIF_STAT_OFS, 8'h10);
      i_eif_pin_src.set_pin(4, 1'b0);
      repeat (60) @(posedge clk);
      wr(`EIF_STAT_OFS, 8'h10);
      rd(`EIF_STAT_OFS, 8'h00);
      // masking, master enable, pin select gating
      wr(`EIF_CTL_OFS, 8'he0);
      i_eif_pin_src.set_pin(4, 1'b1);
      repeat (60) @(posedge clk);
      wr(`EIF_STAT_OFS, 8'h3f);
      wr(`EIF_MASK_OFS, 8'h21);
      i_eif_pin_src.pulse(5, 20);
      repeat (30) @(posedge clk);
      irq_is(1'b1);
      wr(`EIF_MODE_OFS, 8'h00);
      irq_is(1'b0);
      wr(`EIF_MODE_OFS, 8'h01);
      irq_is(1'b1);
      wr(`EIF_STAT_OFS, 8'h20);
      irq_is(1'b0);
      i_eif_pin_src.pulse(0, 20);
      repeat (30) @(posedge clk);
      irq_is(1'b1);
      wr(`EIF_CTL_OFS, 8'ha0);
      irq_is(1'b0);
      wr(`EIF_MASK_OFS, 8'h20);
      wr(`EIF_STAT_OFS, 8'h3f);
      i_eif_pin_src.pulse(0, 20);
      repeat (30) @(posedge clk);
      rd(`EIF_STAT_OFS, 8'h00);
      // edge selects: fall then rise on each choice
      for (int k = 0; k < 9; k++) begin
         i = (k < 6) ? 1 + k / 2 : 4;
         s = (k < 6) ? k % 2 : k - 6;
         wr(`EIF_CTL_OFS, 8'hc0 | 8'(s << ((i == 4) ? 4 : i)));
         wr(`EIF_STAT_OFS, 8'h3f);
         i_eif_pin_src.set_pin(i, 1'b0);
         repeat (120) @(posedge clk);
         rd(`EIF_STAT_OFS, (i == 4 ? s != 0 : s == 1) ? 8'h01 << i
            : 8'h00);
         wr(`EIF_STAT_OFS, 8'h3f);
         i_eif_pin_src.set_pin(i, 1'b1);
         repeat (120) @(posedge clk);
         rd(`EIF_STAT_OFS, (s == 0 || (i == 4 && s == 2)) ? 8'h01 << i
            : 8'h00);
      end
      // random widths, noise select drawn at random for each round
      for (int r = 0; r < 3; r++) begin
         nc = 1'($urandom_range(1));
         wr(`EIF_CTL_OFS, {nc, 7'h60});
         wr(`EIF_STAT_OFS, 8'h3f);
         for (int n = 0; n < 6; n++) begin
            width(n, nc, 1'b0, 1'b0);
            width(n, nc, 1'b1, 1'b0);
         end
      end
      // slow mode on input five
      wr(`EIF_MODE_OFS, 8'h03);
      wr(`EIF_STAT_OFS, 8'h3f);
      width(5, 1'b0, 1'b0, 1'b1);
      width(5, 1'b0, 1'b1, 1'b1);
      results();
   end
endmodule // eif_top_bench
